/* src/dcc_top.sv */
// two capture/compare units with timers, apb registers and interrupt
// Summary of operation
// - each unit: two 16-bit timers with reloads
// - sixteen 16-bit capture/compare registers per unit
// - timer clock: prescaled clock or external overflow
// - first timer can count external pin edges
// - capture or compare chosen per register
// - each register picks either unit timer
// - one pin per register, input or output
// - second unit registers 8..11 capture only
// - pin transition latches allocated timer value
// - compare match toggles the output pin
// - interrupt per cc event and overflow
// - compare events serve as software timers
// - count up, reload on rollover
// - prescaler divides by 8 to 1024
// - second timer serviced one clock later
// - cpu timer write beats increment or reload
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] cc_pin_in,
	output logic [31:0] cc_pin_out,
	output logic [31:0] cc_pin_oe,
	input wire logic [1:0] count_pin,
	input wire logic ext_timer_ovf,
	output logic irq
);
	typedef struct packed {
		logic [3:0][15:0] tmr;
		logic [3:0][15:0] rel;
		logic [1:0][15:0] tcon;
		logic [31:0][15:0] cc;
		logic [31:0][3:0] mode;
		logic [31:0] pout;
		logic [35:0] stat;
		logic [35:0] mask;
		logic [9:0] pre;
		logic [1:0] pend;
		logic [3:0] moved;
		logic [31:0] s1;
		logic [31:0] s2;
		logic [31:0] s3;
		logic [1:0] c1;
		logic [1:0] c2;
		logic [1:0] c3;
		logic [31:0] rdata;
	} dcc_state_t;

	dcc_state_t st;
	dcc_state_t next_st;
	logic acc, wr, rd, hit;
	logic [31:0] rv;
	logic [3:0] ireq, inc, twr;
	logic [31:0] ccwr, cap_ev, cmp_ev, cap_ok;
	logic [31:0][15:0] src;
	logic [7:0] cb;
	logic [9:0] pmask;
	logic tick, ev, rise, fall;
	logic [1:0] ti;

	// compare outputs only where the register may drive
	always_comb begin
		for (int k = 0; k < 32; k++) begin
			cap_ok[k] = (k >= dcc_pkg::CAP_ONLY_LO) && (k <= dcc_pkg::CAP_ONLY_HI);
		end
	end
	assign cc_pin_out = st.pout;
	assign cc_pin_oe = ~cap_ok & cmp_bits();
	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign irq = |(st.stat & st.mask);

	function automatic logic [31:0] cmp_bits();
		logic [31:0] b;
		b = '0;
		for (int k = 0; k < 32; k++) begin
			b[k] = st.mode[k][dcc_pkg::M_CMP];
		end
		return b;
	endfunction

	// next state: bus, timers, capture/compare, interrupt status
	always_comb begin
		next_st = st;
		acc = psel & penable;
		wr = acc & pwrite;
		rd = acc & ~pwrite;
		hit = 1'b0;
		rv = '0;
		ireq = '0;
		inc = '0;
		twr = '0;
		ccwr = '0;
		cap_ev = '0;
		cmp_ev = '0;
		src = '0;
		cb = '0;
		pmask = '0;
		tick = 1'b0;
		ev = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		ti = '0;
		// address decode and read mux
		if (paddr[1:0] == 2'h0) begin
			if (paddr[11:3] == dcc_pkg::R_TCON) begin
				hit = 1'b1;
				rv = {16'h0, st.tcon[paddr[2]]};
			end else if (paddr[11:4] == dcc_pkg::R_TMR) begin
				hit = 1'b1;
				rv = {16'h0, st.tmr[paddr[3:2]]};
			end else if (paddr[11:4] == dcc_pkg::R_REL) begin
				hit = 1'b1;
				rv = {16'h0, st.rel[paddr[3:2]]};
			end else if (paddr[11:7] == dcc_pkg::R_CC) begin
				hit = 1'b1;
				rv = {16'h0, st.cc[paddr[6:2]]};
			end else if (paddr[11:7] == dcc_pkg::R_MODE) begin
				hit = 1'b1;
				rv = {28'h0, st.mode[paddr[6:2]]};
			end else if (paddr[11:4] == dcc_pkg::R_IRQ) begin
				hit = 1'b1;
				case (paddr[3:2])
					2'h0: rv = st.stat[31:0];
					2'h1: rv = {28'h0, st.stat[35:32]};
					2'h2: rv = st.mask[31:0];
					default: rv = {28'h0, st.mask[35:32]};
				endcase
			end
		end
		pslverr = acc & ~hit;
		// read data is captured in the setup cycle
		if (psel & ~penable & ~pwrite) begin
			next_st.rdata = hit ? rv : 32'h0;
		end
		// read clears only the bits actually returned, so later events survive
		if (rd && paddr == dcc_pkg::A_STAT_CC) begin
			next_st.stat[31:0] = st.stat[31:0] & ~st.rdata;
		end
		if (rd && paddr == dcc_pkg::A_STAT_TM) begin
			next_st.stat[35:32] = st.stat[35:32] & ~st.rdata[3:0];
		end
		// register writes
		if (wr && hit) begin
			if (paddr[11:3] == dcc_pkg::R_TCON) begin
				next_st.tcon[paddr[2]] = pwdata[15:0];
			end
			if (paddr[11:4] == dcc_pkg::R_TMR) begin
				twr[paddr[3:2]] = 1'b1;
			end
			if (paddr[11:4] == dcc_pkg::R_REL) begin
				next_st.rel[paddr[3:2]] = pwdata[15:0];
			end
			if (paddr[11:7] == dcc_pkg::R_CC) begin
				ccwr[paddr[6:2]] = 1'b1;
			end
			if (paddr[11:7] == dcc_pkg::R_MODE) begin
				next_st.mode[paddr[6:2]] = pwdata[3:0];
				// capture-only registers never take compare mode
				if (cap_ok[paddr[6:2]]) begin
					next_st.mode[paddr[6:2]][dcc_pkg::M_CMP] = 1'b0;
				end
			end
			if (paddr == dcc_pkg::A_MASK_CC) begin
				next_st.mask[31:0] = pwdata;
			end
			if (paddr == dcc_pkg::A_MASK_TM) begin
				next_st.mask[35:32] = pwdata[3:0];
			end
		end
		// pin synchronisers, edges from second and third stage
		next_st.s1 = cc_pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.c1 = count_pin;
		next_st.c2 = st.c1;
		next_st.c3 = st.c2;
		next_st.pre = st.pre + 10'h001;
		// count sources for the four timers
		for (int t = 0; t < 4; t++) begin
			cb = st.tcon[t / 2][(t % 2) * dcc_pkg::F_HI +: 8];
			pmask = (dcc_pkg::PRE_BASE << cb[2:0]) - 10'h001;
			tick = (st.pre & pmask) == pmask;
			rise = st.c2[t / 2] & ~st.c3[t / 2];
			fall = ~st.c2[t / 2] & st.c3[t / 2];
			if (!cb[dcc_pkg::F_CSEL]) begin
				ev = tick;
			end else if (cb[1:0] == dcc_pkg::C_EXT_OVF) begin
				ev = ext_timer_ovf;
			end else if (t % 2 == 1) begin
				ev = 1'b0; // second timer stops on pin selections
			end else begin
				case (cb[1:0])
					dcc_pkg::C_RISE: ev = rise;
					dcc_pkg::C_FALL: ev = fall;
					dcc_pkg::C_BOTH: ev = rise | fall;
					default: ev = 1'b0;
				endcase
			end
			ireq[t] = cb[dcc_pkg::F_RUN] & ev;
		end
		// second timer of a unit steps one clock after its own count request
		for (int u = 0; u < 2; u++) begin
			inc[2 * u] = ireq[2 * u];
			inc[2 * u + 1] = st.pend[u] & st.tcon[u][dcc_pkg::F_HI + dcc_pkg::F_RUN];
			next_st.pend[u] = ireq[2 * u + 1];
		end
		// timer update: cpu write first, then reload, then increment
		for (int t = 0; t < 4; t++) begin
			next_st.moved[t] = 1'b0;
			if (twr[t]) begin
				next_st.tmr[t] = pwdata[15:0];
			end else if (inc[t]) begin
				next_st.moved[t] = 1'b1;
				if (st.tmr[t] == dcc_pkg::TMR_MAX) begin
					next_st.tmr[t] = st.rel[t];
					next_st.stat[32 + t] = 1'b1;
				end else begin
					next_st.tmr[t] = st.tmr[t] + 16'h0001;
				end
			end
		end
		// capture/compare bank, each register configured on its own
		for (int k = 0; k < 32; k++) begin
			ti = {k[4], st.mode[k][dcc_pkg::M_TSEL]};
			src[k] = st.tmr[ti];
			rise = st.s2[k] & ~st.s3[k];
			fall = ~st.s2[k] & st.s3[k];
			if (!st.mode[k][dcc_pkg::M_CMP]) begin
				cap_ev[k] = (st.mode[k][dcc_pkg::M_EDGE] & rise) | (st.mode[k][dcc_pkg::M_EDGE + 1] & fall);
			end else begin
				// compare ignores the pin and fires only on a timer step that lands on the compare value
				cmp_ev[k] = st.moved[ti] & (st.cc[k] == src[k]);
			end
			if (ccwr[k]) begin
				next_st.cc[k] = pwdata[15:0];
			end else if (cap_ev[k]) begin
				next_st.cc[k] = src[k];
			end
			if (cmp_ev[k]) begin
				next_st.pout[k] = ~st.pout[k];
			end
			// set after clear, so an event in the clearing read survives
			if (cap_ev[k] | cmp_ev[k]) begin
				next_st.stat[k] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking dcc_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence dcc_lag_req_s;
		ireq[1] ##1 (!twr[1] && st.tcon[0][dcc_pkg::F_HI + dcc_pkg::F_RUN] && st.tmr[1] != dcc_pkg::TMR_MAX);
	endsequence

	// checks
	reload_on_wrap_a: assert property (inc[0] && !twr[0] && st.tmr[0] == 16'hffff |=> st.tmr[0] == $past(st.rel[0]))
		else $error("timer did not reload on wrap");
	second_lag_a: assert property (dcc_lag_req_s |=> st.tmr[1] == $past(st.tmr[1]) + 16'h0001)
		else $error("second timer not stepped one clock after request");
	cpu_write_prio_a: assert property (twr[0] |=> st.tmr[0] == $past(pwdata[15:0]) && !st.moved[0])
		else $error("timer write lost to increment");
	capture_latch_a: assert property (cap_ev[1] && !ccwr[1] |=> st.cc[1] == $past(src[1]))
		else $error("capture did not latch timer");
	compare_toggle_a: assert property (cmp_ev[0] |=> st.pout[0] != $past(st.pout[0]))
		else $error("compare match did not toggle pin");
	capture_only_a: assert property (cc_pin_oe[27:24] == 4'h0 && cmp_ev[27:24] == 4'h0)
		else $error("capture-only register drives or compares");
	event_irq_a: assert property ((cap_ev[1] || cmp_ev[1]) |=> st.stat[1] && (irq || !st.mask[1]))
		else $error("event did not raise interrupt");
	stopped_timer_a: assert property (st.tcon[0][11] && st.tcon[0][9:8] != 2'h0 && !twr[1] && !st.pend[0]
		|=> $stable(st.tmr[1]))
		else $error("second timer counted on pin selection");

	// rising edge seen on the count pin of unit b while its first timer counts rising edges
	sequence dcc_pin_rise_s;
		st.tcon[1][7:0] == 8'h49 && st.c2[1] && !st.c3[1];
	endsequence

	// plain step of the first timer below the wrap point
	count_step_a: assert property (inc[0] && !twr[0] && st.tmr[0] != dcc_pkg::TMR_MAX
		|=> st.tmr[0] == $past(st.tmr[0]) + 16'h0001)
		else $error("timer did not step by one");
	// wrap of the first timer flags an overflow
	overflow_flag_a: assert property (inc[0] && !twr[0] && st.tmr[0] == dcc_pkg::TMR_MAX |=> st.stat[32])
		else $error("overflow status not set");
	// capture event flags its register
	cap_flag_a: assert property (cap_ev[1] |=> st.stat[1])
		else $error("capture status not set");

	// cpu write to a cc register lands
	cc_write_prio_a: assert property (ccwr[1] |=> st.cc[1] == $past(pwdata[15:0]))
		else $error("cc register write lost");
	// compare register takes no pin events
	capture_ignore_a: assert property (st.mode[0][dcc_pkg::M_CMP] |-> !cap_ev[0])
		else $error("compare register captured a pin edge");
	// pin driven exactly in compare mode
	compare_drive_a: assert property (cc_pin_oe[0] == st.mode[0][dcc_pkg::M_CMP])
		else $error("pin enable does not follow mode");
	// output pin only moves on a compare match
	pin_hold_a: assert property (!cmp_ev[0] |=> st.pout[0] == $past(st.pout[0]))
		else $error("compare pin moved without match");

	// count sources of the first timers
	ext_count_a: assert property (dcc_pin_rise_s |-> inc[2])
		else $error("pin edge not counted");
	ovf_count_a: assert property (st.tcon[0][7:0] == 8'h48 && ext_timer_ovf |-> inc[0])
		else $error("external overflow not counted");
	prescale_tick_a: assert property (st.tcon[0][7:0] == 8'h40 && st.pre[2:0] == 3'h7 |-> inc[0])
		else $error("divide by eight tick missing");
	// unit b registers take a unit b time base
	unit_b_base_a: assert property (src[16] == (st.mode[16][dcc_pkg::M_TSEL] ? st.tmr[3] : st.tmr[2]))
		else $error("wrong time base for unit b register");

endmodule
`default_nettype wire

/* src/dcc_pkg.sv */
// constants for the dual capture/compare block
package dcc_pkg;
	// register map, byte addresses
	localparam logic [11:0] A_TCON = 12'h000;
	localparam logic [11:0] A_TMR = 12'h010;
	localparam logic [11:0] A_REL = 12'h020;
	localparam logic [11:0] A_CC = 12'h080;
	localparam logic [11:0] A_MODE = 12'h100;
	localparam logic [11:0] A_STAT_CC = 12'h180;
	localparam logic [11:0] A_STAT_TM = 12'h184;
	localparam logic [11:0] A_MASK_CC = 12'h188;
	localparam logic [11:0] A_MASK_TM = 12'h18c;
	// address region selectors
	localparam logic [8:0] R_TCON = 9'h000;
	localparam logic [7:0] R_TMR = 8'h01;
	localparam logic [7:0] R_REL = 8'h02;
	localparam logic [4:0] R_CC = 5'h01;
	localparam logic [4:0] R_MODE = 5'h02;
	localparam logic [7:0] R_IRQ = 8'h18;
	// timer control byte: low byte first timer, high byte second timer
	localparam int F_PSEL = 0;
	localparam int F_CSEL = 3;
	localparam int F_RUN = 6;
	localparam int F_HI = 8;
	// prescale exponent offset: divide by 2^(sel+3), 8 .. 1024
	localparam logic [9:0] PRE_BASE = 10'h008;
	// cc mode nibble
	localparam int M_CMP = 0;
	localparam int M_TSEL = 1;
	localparam int M_EDGE = 2;
	// counter input selections
	localparam logic [1:0] C_EXT_OVF = 2'h0;
	localparam logic [1:0] C_RISE = 2'h1;
	localparam logic [1:0] C_FALL = 2'h2;
	localparam logic [1:0] C_BOTH = 2'h3;
	// capture-only registers of the second unit
	localparam int CAP_ONLY_LO = 24;
	localparam int CAP_ONLY_HI = 27;
	// reset value and timer wrap point
	localparam logic [15:0] TCON_RST = 16'h0000;
	localparam logic [15:0] TMR_MAX = 16'hffff;
endpackage

/* bench/dcc_pins_model.sv */
// pin-side model: event sources and resolved capture/compare pin levels
`timescale 1ns/1ps
`default_nettype none
module dcc_pins_model (
	input wire logic pclk,
	input wire logic [31:0] cc_pin_out,
	input wire logic [31:0] cc_pin_oe,
	output logic [31:0] cc_pin_in,
	output logic [1:0] count_pin,
	output logic ext_timer_ovf
);
	logic [31:0] drv;
	// wire level: the design drives where enabled, the model elsewhere
	assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv);
	initial begin
		drv = 32'h00000000;
		count_pin = 2'h0;
		ext_timer_ovf = 1'b0;
	end
	// one clock wide overflow pulse from the external timer
	task automatic pulse_ovf();
		@(posedge pclk);
		ext_timer_ovf <= 1'b1;
		@(posedge pclk);
		ext_timer_ovf <= 1'b0;
	endtask
	// hold a level on a pin for a few clocks; 32 and 33 are the count pins
	task automatic set_pin(input int k, input logic v);
		@(posedge pclk);
		if (k >= 32) count_pin[k-32] <= v;
		else drv[k] <= v;
		repeat (4) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

/* bench/dual_capture_compare_units_test.sv */
// self-checking bench for the dual capture/compare block
`timescale 1ns/1ps
`default_nettype none
module dual_capture_compare_units_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, cc_pin_in, cc_pin_out, cc_pin_oe, q;
	logic [1:0] count_pin;
	logic pready, pslverr, ext_timer_ovf, irq, err;
	int miscompares = 0;
	int n_compared = 0;
	int seed = 32'he688;
	int r, base;
	dcc_top u_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .count_pin(count_pin),
		.ext_timer_ovf(ext_timer_ovf), .irq(irq));
	dcc_pins_model u_dcc_pins_model (.pclk(pclk), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
		.cc_pin_in(cc_pin_in), .count_pin(count_pin), .ext_timer_ovf(ext_timer_ovf));
	// free-running clock
	always #25 pclk = ~pclk;
	// compare one value and count the result
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(q, exp);
	endtask
	// verdict and end of run
	task automatic report_and_stop();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end
	// main sequence
	initial begin
		r = $random(seed);
		r = (r & 32'h00007fff) | 32'h00000100;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk(cc_pin_oe, 32'h0);
		chk(cc_pin_out, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd(dcc_pkg::A_TCON, 32'h0);
		apb(1'b0, 12'h800, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		// compare on register 0, forced capture on 24
		apb(1'b1, dcc_pkg::A_MODE, 32'h1);
		apb(1'b1, dcc_pkg::A_MODE + 12'h060, 32'h1);
		chk(cc_pin_oe, 32'h1);
		// rollover from external overflow pulses; second timer counts them a clock late
		apb(1'b1, dcc_pkg::A_REL, r);
		apb(1'b1, dcc_pkg::A_TMR, 32'hfffe);
		apb(1'b1, dcc_pkg::A_MASK_TM, 32'hf);
		apb(1'b1, dcc_pkg::A_TCON, 32'h4848);
		u_dcc_pins_model.pulse_ovf();
		u_dcc_pins_model.pulse_ovf();
		rd(dcc_pkg::A_TMR, r);
		rd(dcc_pkg::A_TMR + 12'h004, 32'h2);
		chk({31'h0, irq}, 32'h1);
		rd(dcc_pkg::A_STAT_TM, 32'h1);
		rd(dcc_pkg::A_STAT_TM, 32'h0);
		// compare match toggles pin 0; second timer stops on its pin selection
		apb(1'b1, dcc_pkg::A_TCON, 32'h4948);
		apb(1'b1, dcc_pkg::A_CC, (r + 1) & 32'hffff);
		u_dcc_pins_model.pulse_ovf();
		repeat (4) @(posedge pclk);
		chk(cc_pin_out & 32'h1, 32'h1);
		rd(dcc_pkg::A_TMR + 12'h004, 32'h2);
		// capture of first timer on rising edge of pin 1
		apb(1'b1, dcc_pkg::A_MODE + 12'h004, 32'h4);
		u_dcc_pins_model.set_pin(1, 1'b1);
		repeat (4) @(posedge pclk);
		rd(dcc_pkg::A_CC + 12'h004, (r + 1) & 32'hffff);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, dcc_pkg::A_MASK_CC, 32'h2);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		rd(dcc_pkg::A_STAT_CC, 32'h3);
		// external pin count on the first timer of unit b
		apb(1'b1, dcc_pkg::A_TCON + 12'h004, 32'h0049);
		for (int i = 0; i < 3; i++) begin
			u_dcc_pins_model.set_pin(33, 1'b1);
			u_dcc_pins_model.set_pin(33, 1'b0);
		end
		rd(dcc_pkg::A_TMR + 12'h008, 32'h3);
		// prescaler divide by 8 over about 800 clocks
		base = (r + 1) & 32'hffff;
		apb(1'b1, dcc_pkg::A_TCON, 32'h0040);
		repeat (800) @(posedge pclk);
		apb(1'b1, dcc_pkg::A_TCON, 32'h0);
		apb(1'b0, dcc_pkg::A_TMR, 32'h0);
		chk(32'(((int'(q[15:0]) - base) inside {[97:103]})), 32'h1);
		report_and_stop();
	end
endmodule
`default_nettype wire
